// ---- verilog/arith_logic_branch_exec.sv ----
// execution datapath for arithmetic, logic, multiply, skip and indirect flow instructions
`timescale 1ns/10ps
module arith_logic_branch_exec
    import exec_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire issue_t issue,
    output logic ready,
    output logic done,
    output wb_t wb,
    output flow_t flow,
    output logic [7:0] sreg
);
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY} state_t;

    state_t state_q, state_d;
    logic [1:0] left_q, left_d;
    logic ready_q, ready_d;
    logic done_q, done_d;
    wb_t wb_q, wb_d;
    flow_t flow_q, flow_d;
    logic [7:0] sreg_q, sreg_d;
    wb_t wb_pend_q, wb_pend_d;
    flow_t flow_pend_q, flow_pend_d;
    logic [7:0] sreg_pend_q, sreg_pend_d;

    logic [WORD_W-1:0] prod;
    logic prod_c;
    logic mul_a_s;
    logic mul_b_s;
    logic mul_frac;

    // 8-bit add or subtract with carry in, returns {h, v, c, result}
    function automatic logic [10:0] addsub(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic sub);
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] lo;
        logic c;
        logic h;
        logic v;
        bb = sub ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h00, cin ^ sub};
        lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin ^ sub};
        c = s[8] ^ sub;
        h = lo[4] ^ sub;
        v = (a[7] == bb[7]) && (s[7] != a[7]);
        return {h, v, c, s[7:0]};
    endfunction

    // arithmetic flags: z, c, n, v, h; every other bit keeps its old value
    function automatic logic [7:0] arith_flags(input logic [7:0] old, input logic [10:0] r,
                                               input logic keep_z);
        logic [7:0] f;
        f = old;
        f[FLAG_Z] = (r[7:0] == 8'h00) && keep_z;
        f[FLAG_C] = r[8];
        f[FLAG_N] = r[7];
        f[FLAG_V] = r[9];
        // sign is not affected by byte arithmetic, so a stale sign survives until a word op
        f[FLAG_H] = r[10];
        return f;
    endfunction

    // logic flags: v cleared, z and n from result, others kept
    function automatic logic [7:0] logic_flags(input logic [7:0] old, input logic [7:0] r);
        logic [7:0] f;
        f = old;
        f[FLAG_Z] = (r == 8'h00);
        f[FLAG_N] = r[7];
        f[FLAG_V] = 1'b0;
        // sign left alone: logic ops affect only zero, negative and overflow
        return f;
    endfunction

    product_unit u_product (
        .a(issue.rd),
        .b(issue.rr),
        .a_signed(mul_a_s),
        .b_signed(mul_b_s),
        .fractional(mul_frac),
        .product(prod),
        .carry_out(prod_c)
    );

    always_comb begin
        mul_a_s = (issue.op == OP_SIGNED_PRODUCT) || (issue.op == OP_MIXED_SIGN_PRODUCT)
               || (issue.op == OP_FRACTIONAL_SIGNED_PRODUCT) || (issue.op == OP_FRACTIONAL_MIXED_PRODUCT);
        mul_b_s = (issue.op == OP_SIGNED_PRODUCT) || (issue.op == OP_FRACTIONAL_SIGNED_PRODUCT);
        mul_frac = (issue.op == OP_FRACTIONAL_UNSIGNED_PRODUCT) || (issue.op == OP_FRACTIONAL_SIGNED_PRODUCT)
                || (issue.op == OP_FRACTIONAL_MIXED_PRODUCT);
    end

    always_comb begin
        logic [10:0] r;
        logic [7:0] lr;
        logic [16:0] w;
        logic [WORD_W-1:0] wr;
        logic [1:0] cyc;
        logic skip;
        logic [7:0] f;
        wb_t nwb;
        flow_t nfl;
        r = '0;
        lr = '0;
        w = '0;
        wr = '0;
        cyc = CYC_ONE;
        skip = 1'b0;
        f = sreg_q;
        nwb = '0;
        nfl = '0;
        state_d = state_q;
        left_d = left_q;
        ready_d = ready_q;
        done_d = 1'b0;
        wb_d = '0;
        flow_d = '0;
        sreg_d = sreg_q;
        wb_pend_d = wb_pend_q;
        flow_pend_d = flow_pend_q;
        sreg_pend_d = sreg_pend_q;
        unique case (state_q)
            ST_IDLE: begin
                ready_d = 1'b1;
                if (issue_valid && ready_q) begin
                    unique case (issue.op)
                        OP_ADD, OP_ADD_CARRY: begin
                            r = addsub(issue.rd, issue.rr, (issue.op == OP_ADD_CARRY) & sreg_q[FLAG_C], 1'b0);
                            f = arith_flags(sreg_q, r, 1'b1);
                            nwb.byte_we = 1'b1;
                            nwb.byte_val = r[7:0];
                        end
                        OP_SUBTRACT_IMMEDIATE, OP_COMPARE_IMMEDIATE: begin
                            r = addsub(issue.rd, issue.imm, 1'b0, 1'b1);
                            f = arith_flags(sreg_q, r, 1'b1);
                            nwb.byte_we = (issue.op == OP_SUBTRACT_IMMEDIATE);
                            nwb.byte_val = r[7:0];
                        end
                        OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_CONSTANT_WITH_BORROW: begin
                            lr = (issue.op == OP_SUBTRACT_WITH_BORROW) ? issue.rr : issue.imm;
                            r = addsub(issue.rd, lr, sreg_q[FLAG_C], 1'b1);
                            // zero only stays set if it was already set, so chained bytes compare whole words
                            f = arith_flags(sreg_q, r, sreg_q[FLAG_Z]);
                            nwb.byte_we = 1'b1;
                            nwb.byte_val = r[7:0];
                        end
                        OP_CONJUNCTION, OP_BITWISE_CONJUNCTION_IMMEDIATE, OP_BIT_CLEAR_MASK,
                        OP_TEST_ZERO_MINUS: begin
                            unique case (issue.op)
                                OP_CONJUNCTION: lr = issue.rd & issue.rr;
                                OP_BITWISE_CONJUNCTION_IMMEDIATE: lr = issue.rd & issue.imm;
                                OP_BIT_CLEAR_MASK: lr = issue.rd & (ALL_ONES - issue.imm);
                                default: lr = issue.rd & issue.rd;
                            endcase
                            f = logic_flags(sreg_q, lr);
                            nwb.byte_we = 1'b1;
                            nwb.byte_val = lr;
                        end
                        OP_DISJUNCTION, OP_BITWISE_DISJUNCTION_IMMEDIATE, OP_BIT_SET_MASK: begin
                            lr = issue.rd | ((issue.op == OP_DISJUNCTION) ? issue.rr : issue.imm);
                            f = logic_flags(sreg_q, lr);
                            nwb.byte_we = 1'b1;
                            nwb.byte_val = lr;
                        end
                        OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE: begin
                            cyc = CYC_TWO;
                            if (issue.op == OP_WORD_ADD_IMMEDIATE) begin
                                w = {1'b0, issue.word} + {11'h000, issue.imm[5:0]};
                                wr = w[15:0];
                                f[FLAG_C] = ~wr[15] & issue.word[15];
                                f[FLAG_V] = ~issue.word[15] & wr[15];
                            end else begin
                                w = {1'b0, issue.word} - {11'h000, issue.imm[5:0]};
                                wr = w[15:0];
                                f[FLAG_C] = wr[15] & ~issue.word[15];
                                f[FLAG_V] = issue.word[15] & ~wr[15];
                            end
                            f[FLAG_Z] = (wr == 16'h0000);
                            f[FLAG_N] = wr[15];
                            f[FLAG_S] = wr[15] ^ f[FLAG_V];
                            nwb.word_we = 1'b1;
                            nwb.word_val = wr;
                        end
                        OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
                        OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
                        OP_FRACTIONAL_MIXED_PRODUCT: begin
                            cyc = CYC_TWO;
                            f[FLAG_C] = prod_c;
                            f[FLAG_Z] = (prod == 16'h0000);
                            nwb.product_we = 1'b1;
                            nwb.product_val = prod;
                        end
                        OP_COMPARE_SKIP_EQUAL, OP_SKIP_BIT_CLEAR: begin
                            skip = (issue.op == OP_COMPARE_SKIP_EQUAL) ? (issue.rd == issue.rr)
                                 : ~issue.rr[issue.bit_sel];
                            if (skip) begin
                                cyc = issue.next_is_long ? CYC_THREE : CYC_TWO;
                                nfl.pc_we = 1'b1;
                                nfl.pc_val = issue.pc + (issue.next_is_long ? 16'h0003 : 16'h0002);
                            end
                        end
                        OP_INDIRECT_JUMP: begin
                            cyc = CYC_TWO;
                            nfl.pc_we = 1'b1;
                            nfl.pc_val = issue.z_ptr;
                        end
                        OP_INDIRECT_SUBROUTINE_CALL: begin
                            cyc = CYC_THREE;
                            nfl.pc_we = 1'b1;
                            nfl.pc_val = issue.z_ptr;
                            nfl.push_we = 1'b1;
                            nfl.push_val = issue.pc + PC_STEP;
                        end
                        default: begin
                        end
                    endcase
                    if (cyc == CYC_ONE) begin
                        done_d = 1'b1;
                        wb_d = nwb;
                        flow_d = nfl;
                        sreg_d = f;
                    end else begin
                        // results are held until the last cycle so completion is one coherent event
                        state_d = ST_BUSY;
                        left_d = cyc - CYC_TWO;
                        ready_d = 1'b0;
                        wb_pend_d = nwb;
                        flow_pend_d = nfl;
                        sreg_pend_d = f;
                    end
                end
            end
            ST_BUSY: begin
                if (left_q == 2'h0) begin
                    state_d = ST_IDLE;
                    ready_d = 1'b1;
                    done_d = 1'b1;
                    wb_d = wb_pend_q;
                    flow_d = flow_pend_q;
                    sreg_d = sreg_pend_q;
                end else begin
                    left_d = left_q - 2'h1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            left_q <= 2'h0;
            ready_q <= 1'b0;
            done_q <= 1'b0;
            wb_q <= '0;
            flow_q <= '0;
            sreg_q <= SREG_RESET;
            wb_pend_q <= '0;
            flow_pend_q <= '0;
            sreg_pend_q <= SREG_RESET;
        end else begin
            state_q <= state_d;
            left_q <= left_d;
            ready_q <= ready_d;
            done_q <= done_d;
            wb_q <= wb_d;
            flow_q <= flow_d;
            sreg_q <= sreg_d;
            wb_pend_q <= wb_pend_d;
            flow_pend_q <= flow_pend_d;
            sreg_pend_q <= sreg_pend_d;
        end
    end

    assign ready = ready_q;
    assign done = done_q;
    assign wb = wb_q;
    assign flow = flow_q;
    assign sreg = sreg_q;
endmodule

// ---- verilog/exec_pkg.sv ----
// shared types and constants for the arithmetic, logic and branch execution unit
package exec_pkg;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int PC_W = 16;
    // status register bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam logic [7:0] SREG_RESET = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    // cycle counts per instruction class
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_ADD,
        OP_ADD_CARRY,
        OP_WORD_ADD_IMMEDIATE,
        OP_WORD_SUBTRACT_IMMEDIATE,
        OP_SUBTRACT_IMMEDIATE,
        OP_SUBTRACT_WITH_BORROW,
        OP_SUBTRACT_CONSTANT_WITH_BORROW,
        OP_CONJUNCTION,
        OP_BITWISE_CONJUNCTION_IMMEDIATE,
        OP_DISJUNCTION,
        OP_BITWISE_DISJUNCTION_IMMEDIATE,
        OP_BIT_CLEAR_MASK,
        OP_BIT_SET_MASK,
        OP_TEST_ZERO_MINUS,
        OP_UNSIGNED_PRODUCT,
        OP_SIGNED_PRODUCT,
        OP_MIXED_SIGN_PRODUCT,
        OP_FRACTIONAL_UNSIGNED_PRODUCT,
        OP_FRACTIONAL_SIGNED_PRODUCT,
        OP_FRACTIONAL_MIXED_PRODUCT,
        OP_COMPARE_SKIP_EQUAL,
        OP_COMPARE_IMMEDIATE,
        OP_SKIP_BIT_CLEAR,
        OP_INDIRECT_JUMP,
        OP_INDIRECT_SUBROUTINE_CALL
    } op_t;

    // one instruction as handed over by fetch and register file
    typedef struct packed {
        op_t op;
        logic [DATA_W-1:0] rd;
        logic [DATA_W-1:0] rr;
        logic [WORD_W-1:0] word;
        logic [DATA_W-1:0] imm;
        logic [2:0] bit_sel;
        logic next_is_long;
        logic [PC_W-1:0] pc;
        logic [PC_W-1:0] z_ptr;
    } issue_t;

    typedef struct packed {
        logic byte_we;
        logic [DATA_W-1:0] byte_val;
        logic word_we;
        logic [WORD_W-1:0] word_val;
        logic product_we;
        logic [WORD_W-1:0] product_val;
    } wb_t;

    typedef struct packed {
        logic pc_we;
        logic [PC_W-1:0] pc_val;
        logic push_we;
        logic [PC_W-1:0] push_val;
    } flow_t;
endpackage

// ---- verilog/product_unit.sv ----
// 8x8 multiplier with signed, unsigned and mixed operand modes and fractional shift
`timescale 1ns/10ps
module product_unit
    import exec_pkg::*;
(
    input wire logic [DATA_W-1:0] a,
    input wire logic [DATA_W-1:0] b,
    input wire logic a_signed,
    input wire logic b_signed,
    input wire logic fractional,
    output logic [WORD_W-1:0] product,
    output logic carry_out
);
    logic signed [17:0] full;
    logic signed [8:0] a_ext;
    logic signed [8:0] b_ext;

    always_comb begin
        a_ext = {a_signed & a[DATA_W-1], a};
        b_ext = {b_signed & b[DATA_W-1], b};
        full = a_ext * b_ext;
        // carry is bit 15 of the raw product, taken before the fractional shift
        carry_out = full[15];
        if (fractional) begin
            product = {full[14:0], 1'b0};
        end else begin
            product = full[15:0];
        end
    end
endmodule

// ---- bench/exec_props.sv ----
// concurrent checks on the execution datapath ports
`timescale 1ns/10ps
module exec_props
    import exec_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire issue_t issue,
    input wire logic ready,
    input wire logic done,
    input wire wb_t wb,
    input wire flow_t flow,
    input wire logic [7:0] sreg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic go;
    assign go = issue_valid && ready;

    a_add_one_cycle: assert property (go && issue.op == OP_ADD |=> done && wb.byte_we
        && wb.byte_val == $past(issue.rd) + $past(issue.rr)) else $error("register add late or wrong");
    a_word_add_two: assert property (go && issue.op == OP_WORD_ADD_IMMEDIATE |=> !ready ##1 done
        && wb.word_we && wb.word_val == $past(issue.word, 2) + $past(issue.imm[5:0], 2))
        else $error("word add late or wrong");
    a_word_sub_two: assert property (go && issue.op == OP_WORD_SUBTRACT_IMMEDIATE |=> !ready ##1 done
        && wb.word_we && wb.word_val == $past(issue.word, 2) - $past(issue.imm[5:0], 2))
        else $error("word subtract late or wrong");
    a_product_two: assert property (go && issue.op inside {OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT,
        OP_MIXED_SIGN_PRODUCT} |=> !ready ##1 done && wb.product_we) else $error("product not in two cycles");
    a_fraction_even: assert property (go && issue.op inside {OP_FRACTIONAL_UNSIGNED_PRODUCT,
        OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT} |=> ##1 done && !wb.product_val[0])
        else $error("fractional product not shifted");
    a_compare_no_write: assert property (go && issue.op == OP_COMPARE_IMMEDIATE |=> done && !wb.byte_we)
        else $error("compare wrote a register");
    a_skip_equal_short: assert property (go && issue.op == OP_COMPARE_SKIP_EQUAL && issue.rd == issue.rr
        && !issue.next_is_long |=> !ready ##1 done && flow.pc_we && flow.pc_val == $past(issue.pc, 2) + 16'h0002)
        else $error("equal skip wrong");
    a_skip_bit_long: assert property (go && issue.op == OP_SKIP_BIT_CLEAR && !issue.rr[issue.bit_sel]
        && issue.next_is_long |=> !ready [*2] ##1 done && flow.pc_val == $past(issue.pc, 3) + 16'h0003)
        else $error("bit skip wrong");
    a_jump_two: assert property (go && issue.op == OP_INDIRECT_JUMP |=> !ready ##1 done && flow.pc_we
        && flow.pc_val == $past(issue.z_ptr, 2) && !flow.push_we) else $error("indirect jump wrong");
    a_call_three: assert property (go && issue.op == OP_INDIRECT_SUBROUTINE_CALL |=> !ready [*2] ##1 done
        && flow.pc_val == $past(issue.z_ptr, 3) && flow.push_we && flow.push_val == $past(issue.pc, 3) + 16'h0001)
        else $error("indirect call wrong");
    a_flags_with_done: assert property ($changed(sreg) |-> done) else $error("flags moved without completion");
    a_logic_holds_carry: assert property (go && issue.op inside {OP_CONJUNCTION, OP_DISJUNCTION} |=> done
        && sreg[FLAG_C] == $past(sreg[FLAG_C]) && !sreg[FLAG_V]) else $error("logic op touched carry");
endmodule

// ---- bench/fetch_model.sv ----
// fetch and register-file stand-in that presents one instruction at a time
`timescale 1ns/10ps
module fetch_model
    import exec_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ready,
    output logic issue_valid,
    output issue_t issue
);
    initial begin
        issue_valid = 1'b0;
        issue = '0;
    end
    // holds the request for up to 8 falling edges until one sees ready, so a core busy for fewer cycles never loses it
    task automatic offer(input issue_t ins, input int stall);
        @(negedge clk);
        repeat (stall) @(negedge clk);
        issue = ins;
        issue_valid = 1'b1;
        // ready is registered, so its falling-edge value is what the next rising edge samples
        for (int n = 0; n < 8 && ready !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
    endtask
    // released lines show the inverse of the last value so nothing stale can match
    task automatic withdraw();
        @(negedge clk);
        issue_valid = 1'b0;
        issue = ~issue;
    endtask
endmodule

// ---- bench/arith_logic_branch_exec_test.sv ----
// self-checking bench for the execution datapath
`timescale 1ns/10ps
module arith_logic_branch_exec_test;
    import exec_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic issue_valid;
    issue_t issue;
    logic ready;
    logic done;
    wb_t wb;
    flow_t flow;
    logic [7:0] sreg;
    logic [7:0] sr = 8'h00;
    int error_cnt = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    fetch_model fetch_u (.clk(clk), .rst_n(rst_n), .ready(ready), .issue_valid(issue_valid), .issue(issue));
    arith_logic_branch_exec dut_u (.clk(clk), .rst_n(rst_n), .issue_valid(issue_valid), .issue(issue),
        .ready(ready), .done(done), .wb(wb), .flow(flow), .sreg(sreg));

    task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic issue_t mk(input op_t op, input logic [7:0] a, input logic [7:0] b);
        mk = '0;
        mk.op = op;
        mk.rd = a;
        mk.rr = b;
        mk.imm = b;
        mk.bit_sel = 3'h3;
        mk.pc = 16'h0100;
        mk.z_ptr = 16'h2468;
    endfunction
    // byte add or subtract flags; unlisted bits keep the running expectation
    function automatic logic [7:0] ar(input logic [7:0] a, input logic [7:0] b, input logic ci, input logic sub,
                                      input logic keepz);
        logic [8:0] r;
        logic [4:0] h;
        r = sub ? {1'b0, a} - b - ci : {1'b0, a} + b + ci;
        h = sub ? {1'b0, a[3:0]} - b[3:0] - ci : {1'b0, a[3:0]} + b[3:0] + ci;
        ar = sr;
        ar[FLAG_C] = r[8];
        ar[FLAG_Z] = (r[7:0] == 8'h00) && (!keepz || sr[FLAG_Z]);
        ar[FLAG_N] = r[7];
        ar[FLAG_V] = sub ? (a[7] != b[7]) && (r[7] != a[7]) : (a[7] == b[7]) && (r[7] != a[7]);
        ar[FLAG_H] = h[4];
    endfunction
    task automatic run(input issue_t ins, input int cyc, input int stall = 0);
        int n;
        n = 1;
        fetch_u.offer(ins, stall);
        fetch_u.withdraw();
        while (done !== 1'b1 && n < 6) begin
            @(negedge clk);
            n++;
        end
        check("cycles", cyc, n);
    endtask
    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        check("reset flags", SREG_RESET, sreg);
        check("reset ready", 1'b0, ready);
        rst_n = 1'b1;
        sr = SREG_RESET;
    endtask
    task automatic arith_ops();
        op_t ops[6];
        logic [7:0] a[6];
        logic [7:0] b[6];
        logic ci;
        logic [7:0] e;
        ops = '{OP_ADD, OP_ADD_CARRY, OP_SUBTRACT_IMMEDIATE, OP_SUBTRACT_WITH_BORROW,
                OP_SUBTRACT_CONSTANT_WITH_BORROW, OP_COMPARE_IMMEDIATE};
        a = '{8'h8F, 8'h0F, 8'h10, 8'h20, 8'h20, 8'h35};
        b = '{8'h91, 8'hF0, 8'h11, 8'h1F, 8'h1F, 8'h35};
        for (int k = 0; k < 6; k++) begin
            ci = (k == 1 || k == 3 || k == 4) ? sr[FLAG_C] : 1'b0;
            e = (k < 2) ? a[k] + b[k] + ci : a[k] - b[k] - ci;
            sr = ar(a[k], b[k], ci, k >= 2, k == 3 || k == 4);
            run(mk(ops[k], a[k], b[k]), 1);
            check("byte_we", k != 5, wb.byte_we);
            if (k != 5) check("result", e, wb.byte_val);
            check("flags", sr, sreg);
        end
    endtask
    task automatic word_ops();
        issue_t i;
        logic [16:0] r;
        for (int k = 0; k < 2; k++) begin
            i = mk(k ? OP_WORD_ADD_IMMEDIATE : OP_WORD_SUBTRACT_IMMEDIATE, 8'h00, k ? 8'hC6 : 8'hC1);
            i.word = k ? 16'hFFFA : 16'h8000;
            r = k ? {1'b0, i.word} + i.imm[5:0] : {1'b0, i.word} - i.imm[5:0];
            sr[FLAG_C] = r[16];
            sr[FLAG_Z] = r[15:0] == 16'h0000;
            sr[FLAG_N] = r[15];
            sr[FLAG_V] = k ? !i.word[15] && r[15] : i.word[15] && !r[15];
            sr[FLAG_S] = sr[FLAG_N] ^ sr[FLAG_V];
            run(i, 2);
            check("word", {1'b1, r[15:0]}, {wb.word_we, wb.word_val});
            check("flags", sr, sreg);
        end
    endtask
    task automatic logic_ops();
        op_t ops[7];
        logic [7:0] e[7];
        ops = '{OP_CONJUNCTION, OP_BITWISE_CONJUNCTION_IMMEDIATE, OP_DISJUNCTION,
                OP_BITWISE_DISJUNCTION_IMMEDIATE, OP_BIT_CLEAR_MASK, OP_BIT_SET_MASK, OP_TEST_ZERO_MINUS};
        e = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'hA5, 8'hFF, 8'hA5};
        for (int k = 0; k < 7; k++) begin
            sr[FLAG_Z] = e[k] == 8'h00;
            sr[FLAG_N] = e[k][7];
            sr[FLAG_V] = 1'b0;
            run(mk(ops[k], 8'hA5, 8'h5A), 1);
            check("result", e[k], wb.byte_val);
            check("flags", sr, sreg);
        end
    endtask
    task automatic product_ops();
        op_t ops[6];
        int x;
        int y;
        logic [15:0] p;
        logic [15:0] w;
        ops = '{OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT, OP_FRACTIONAL_UNSIGNED_PRODUCT,
                OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT};
        for (int k = 0; k < 6; k++) begin
            x = (k % 3 != 0) ? -64 : 192;
            y = (k % 3 == 1) ? -112 : 144;
            p = 16'(x * y);
            w = (k >= 3) ? {p[14:0], 1'b0} : p;
            sr[FLAG_C] = p[15];
            sr[FLAG_Z] = w == 16'h0000;
            run(mk(ops[k], 8'hC0, 8'h90), 2);
            check("product", w, wb.product_val);
            check("flags", sr, sreg);
        end
    endtask
    task automatic back_to_back();
        sr = ar(8'h01, 8'h02, 1'b0, 1'b0, 1'b0);
        sr = ar(8'h10, 8'h20, 1'b0, 1'b0, 1'b0);
        fetch_u.offer(mk(OP_ADD, 8'h01, 8'h02), 0);
        fetch_u.offer(mk(OP_ADD, 8'h10, 8'h20), 0);
        fetch_u.withdraw();
        check("second sum", {1'b1, 8'h30}, {done, wb.byte_val});
        check("flags", sr, sreg);
    endtask
    task automatic flow_ops();
        issue_t i;
        flow_t f;
        op_t ops[7];
        logic [7:0] a[7];
        logic [7:0] b[7];
        int c[7];
        ops = '{OP_COMPARE_SKIP_EQUAL, OP_COMPARE_SKIP_EQUAL, OP_COMPARE_SKIP_EQUAL, OP_SKIP_BIT_CLEAR,
                OP_SKIP_BIT_CLEAR, OP_INDIRECT_JUMP, OP_INDIRECT_SUBROUTINE_CALL};
        a = '{8'h5A, 8'h5A, 8'h5A, 8'hF7, 8'h08, 8'h00, 8'h00};
        b = '{8'h5A, 8'h5A, 8'h5B, 8'hF7, 8'h08, 8'h00, 8'h00};
        c = '{2, 3, 1, 3, 1, 2, 3};
        for (int k = 0; k < 7; k++) begin
            i = mk(ops[k], a[k], b[k]);
            i.next_is_long = (k == 1 || k == 3);
            f = '0;
            f.pc_we = c[k] > 1;
            f.pc_val = (k >= 5) ? 16'h2468 : (c[k] > 1 ? 16'h0100 + 16'(c[k]) : 16'h0000);
            f.push_we = k == 6;
            f.push_val = (k == 6) ? 16'h0101 : 16'h0000;
            // odd cases come from a slow fetch
            run(i, c[k], k % 2);
            check("flow", f, flow);
            check("flags", sr, sreg);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        arith_ops();
        word_ops();
        logic_ops();
        product_ops();
        back_to_back();
        do_reset();
        flow_ops();
        complete_run();
    end
    // the whole sequence needs well under 2000 cycles
    initial begin
        #20000;
        error_cnt++;
        complete_run();
    end
endmodule

bind arith_logic_branch_exec exec_props chk_u (.clk(clk), .rst_n(rst_n), .issue_valid(issue_valid),
    .issue(issue), .ready(ready), .done(done), .wb(wb), .flow(flow), .sreg(sreg));
